// file: logic/fcpwm_top.sv
`timescale 1ns/1ps

module fcpwm_top
	import fcpwm_pkg::*;
#(
	parameter int unsigned NCH = NUM_CH
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	// Waveforms and interrupt
	output logic [NCH-1:0] channel_wave_out,
	output logic irq
);

	logic [PRESC_W-1:0] presc_q, presc_d;
	logic [PRE_TAPS-1:0] tap;
	logic [DIV_W-1:0] div_factor_q [NUM_DIV];
	logic [DIV_W-1:0] div_factor_d [NUM_DIV];
	logic [PRE_W-1:0] div_source_q [NUM_DIV];
	logic [PRE_W-1:0] div_source_d [NUM_DIV];
	logic [DIV_W-1:0] div_cnt_q [NUM_DIV];
	logic [DIV_W-1:0] div_cnt_d [NUM_DIV];
	logic [NUM_DIV-1:0] div_tick;

	fcpwm_chcfg_t cfg_q [NCH];
	fcpwm_chcfg_t cfg_d [NCH];
	fcpwm_chst_t st_q [NCH];
	fcpwm_chst_t st_d [NCH];
	logic [NCH-1:0] en_q, en_d;
	logic [NCH-1:0] imr_q, imr_d;
	logic [NCH-1:0] isr_q, isr_d;
	logic [NCH-1:0] wave_q, wave_d;
	logic [NCH-1:0] ch_tick;
	logic [NCH-1:0] ev;
	logic irq_q, irq_d;
	logic pready_q, pready_d;
	logic [DATA_W-1:0] prdata_q, prdata_d;

	logic setup_done;
	logic xfer_wr;
	logic xfer_rd;
	logic in_ch;
	logic [ADDR_W-1:0] ch_rel;
	logic [CH_IDX_W-1:0] ch_idx;
	logic [CH_SUB_W-1:0] ch_sub;
	logic [DATA_W-1:0] rd_mux;

	// APB decode; every access takes one wait state.
	assign setup_done = psel & penable & ~pready_q;
	assign xfer_wr = psel & penable & pready_q & pwrite;
	assign xfer_rd = psel & penable & pready_q & ~pwrite;
	assign in_ch = (paddr >= OFF_CH_BASE) && (paddr < OFF_CH_END);
	assign ch_rel = paddr - OFF_CH_BASE;
	assign ch_idx = ch_rel[CH_IDX_LSB +: CH_IDX_W];
	assign ch_sub = ch_rel[CH_SUB_W-1:0];

	// Clock generator: prescaler taps and two linear dividers.
	always_comb begin
		presc_d = presc_q + PRESC_W'(1);
		// Tap k pulses once every 2**k master clocks; tap 0 is the undivided clock.
		for (int k = 0; k < PRE_TAPS; k++) begin
			tap[k] = (presc_q & PRESC_W'((1 << k) - 1)) == PRESC_W'((1 << k) - 1);
		end
		for (int d = 0; d < NUM_DIV; d++) begin
			div_factor_d[d] = div_factor_q[d];
			div_source_d[d] = div_source_q[d];
			div_cnt_d[d] = div_cnt_q[d];
			div_tick[d] = 1'b0;
			if (div_factor_q[d] == DIV_RESET) begin
				div_cnt_d[d] = DIV_RESET;
			end else if (div_source_q[d] < PRE_W'(PRE_TAPS) && tap[div_source_q[d]]) begin
				if (div_cnt_q[d] == div_factor_q[d] - DIV_W'(1)) begin
					div_cnt_d[d] = DIV_RESET;
					div_tick[d] = 1'b1;
				end else begin
					div_cnt_d[d] = div_cnt_q[d] + DIV_W'(1);
				end
			end
		end
		// Configuration writes land even while no channel runs.
		if (xfer_wr && paddr == OFF_CLOCK_GEN_CONFIG) begin
			div_factor_d[0] = pwdata[FACTOR_A_LSB +: DIV_W];
			div_source_d[0] = pwdata[SOURCE_A_LSB +: PRE_W];
			div_factor_d[1] = pwdata[FACTOR_B_LSB +: DIV_W];
			div_source_d[1] = pwdata[SOURCE_B_LSB +: PRE_W];
			div_cnt_d[0] = DIV_RESET;
			div_cnt_d[1] = DIV_RESET;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q <= '0;
			for (int d = 0; d < NUM_DIV; d++) begin
				div_factor_q[d] <= DIV_RESET;
				div_source_q[d] <= PRE_RESET;
				div_cnt_q[d] <= DIV_RESET;
			end
		end else begin
			presc_q <= presc_d;
			div_factor_q <= div_factor_d;
			div_source_q <= div_source_d;
			div_cnt_q <= div_cnt_d;
		end
	end

	// Channels, enables and interrupt flags.
	always_comb begin
		logic [CNT_W:0] thr;
		logic [CNT_W:0] nxt;
		logic fin;
		thr = '0;
		nxt = '0;
		fin = 1'b0;
		en_d = en_q;
		imr_d = imr_q;
		// Only flags already returned by a status read are cleared, so a new one survives.
		isr_d = isr_q;
		if (xfer_rd && paddr == OFF_IRQ_STATUS) begin
			isr_d = isr_q & ~prdata_q[NCH-1:0];
		end
		if (xfer_wr) begin
			unique case (paddr)
				OFF_CHANNEL_ENABLE: en_d = en_q | pwdata[NCH-1:0];
				OFF_CHANNEL_DISABLE: en_d = en_q & ~pwdata[NCH-1:0];
				OFF_IRQ_ENABLE: imr_d = imr_q | pwdata[NCH-1:0];
				OFF_IRQ_DISABLE: imr_d = imr_q & ~pwdata[NCH-1:0];
				default: begin
				end
			endcase
		end
		for (int c = 0; c < NCH; c++) begin
			cfg_d[c] = cfg_q[c];
			st_d[c] = st_q[c];
			ev[c] = 1'b0;
			unique case (cfg_q[c].clk_sel)
				SEL_CLOCK_A: ch_tick[c] = div_tick[0];
				SEL_CLOCK_B: ch_tick[c] = div_tick[1];
				default: ch_tick[c] = (cfg_q[c].clk_sel < SEL_W'(PRE_TAPS)) &&
					tap[cfg_q[c].clk_sel];
			endcase
			if (en_q[c] && ch_tick[c]) begin
				nxt = {1'b0, st_q[c].count} + (CNT_W+1)'(1);
				fin = 1'b0;
				if (!cfg_q[c].center) begin
					if (nxt >= {1'b0, cfg_q[c].period}) begin
						st_d[c].count = CNT_RESET;
						fin = 1'b1;
					end else begin
						st_d[c].count = nxt[CNT_W-1:0];
					end
				end else if (st_q[c].dir == FCPWM_UP) begin
					st_d[c].count = nxt[CNT_W-1:0];
					if (nxt >= {1'b0, cfg_q[c].period}) begin
						st_d[c].count = cfg_q[c].period;
						st_d[c].dir = FCPWM_DOWN;
					end
				end else if (st_q[c].count <= CNT_W'(1)) begin
					st_d[c].count = CNT_RESET;
					st_d[c].dir = FCPWM_UP;
					fin = 1'b1;
				end else begin
					st_d[c].count = st_q[c].count - CNT_W'(1);
				end
				ev[c] = fin;
				if (fin && st_q[c].upd_pend) begin
					st_d[c].upd_pend = 1'b0;
					if (cfg_q[c].upd_duty) begin
						cfg_d[c].duty = st_q[c].upd_val;
					end else begin
						cfg_d[c].period = st_q[c].upd_val;
					end
				end
			end
			if (xfer_wr && in_ch && ch_idx == CH_IDX_W'(c)) begin
				unique case (ch_sub)
					SUB_MODE: begin
						cfg_d[c].clk_sel = pwdata[SEL_LSB +: SEL_W];
						cfg_d[c].upd_duty = pwdata[TARGET_BIT];
						if (!en_q[c]) begin
							cfg_d[c].center = pwdata[CENTER_BIT];
							cfg_d[c].start_level = pwdata[LEVEL_BIT];
						end
					end
					SUB_DUTY: if (!en_q[c]) cfg_d[c].duty = pwdata[CNT_W-1:0];
					SUB_PERIOD: if (!en_q[c]) cfg_d[c].period = pwdata[CNT_W-1:0];
					SUB_UPDATE: begin
						st_d[c].upd_val = pwdata[CNT_W-1:0];
						st_d[c].upd_pend = 1'b1;
					end
					default: begin
					end
				endcase
			end
			if (!en_q[c] && en_d[c]) begin
				st_d[c].count = CNT_RESET;
				st_d[c].dir = FCPWM_UP;
				st_d[c].upd_pend = 1'b0;
			end
			// Waveform is computed from the next state so it leaves a flop aligned with it.
			thr = {1'b0, cfg_d[c].period} - {1'b0, cfg_d[c].duty};
			if (!en_d[c]) begin
				wave_d[c] = cfg_d[c].start_level;
			end else if (st_d[c].dir == FCPWM_UP) begin
				wave_d[c] = ({1'b0, st_d[c].count} < thr) ? ~cfg_d[c].start_level :
					cfg_d[c].start_level;
			end else begin
				wave_d[c] = ({1'b0, st_d[c].count} <= thr) ? ~cfg_d[c].start_level :
					cfg_d[c].start_level;
			end
		end
		isr_d = isr_d | ev;
		irq_d = |(isr_d & imr_d);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NCH; c++) begin
				cfg_q[c] <= CHCFG_RESET;
				st_q[c] <= CHST_RESET;
			end
			en_q <= '0;
			imr_q <= '0;
			isr_q <= '0;
			wave_q <= '0;
			irq_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			st_q <= st_d;
			en_q <= en_d;
			imr_q <= imr_d;
			isr_q <= isr_d;
			wave_q <= wave_d;
			irq_q <= irq_d;
		end
	end

	// Read multiplexer; write-only and unmapped words read zero.
	always_comb begin
		rd_mux = '0;
		if (in_ch) begin
			unique case (ch_sub)
				SUB_MODE: begin
					rd_mux[SEL_LSB +: SEL_W] = cfg_q[ch_idx].clk_sel;
					rd_mux[CENTER_BIT] = cfg_q[ch_idx].center;
					rd_mux[LEVEL_BIT] = cfg_q[ch_idx].start_level;
					rd_mux[TARGET_BIT] = cfg_q[ch_idx].upd_duty;
				end
				SUB_DUTY: rd_mux[CNT_W-1:0] = cfg_q[ch_idx].duty;
				SUB_PERIOD: rd_mux[CNT_W-1:0] = cfg_q[ch_idx].period;
				SUB_COUNT: rd_mux[CNT_W-1:0] = st_q[ch_idx].count;
				default: begin
				end
			endcase
		end else begin
			unique case (paddr)
				OFF_CLOCK_GEN_CONFIG: begin
					rd_mux[FACTOR_A_LSB +: DIV_W] = div_factor_q[0];
					rd_mux[SOURCE_A_LSB +: PRE_W] = div_source_q[0];
					rd_mux[FACTOR_B_LSB +: DIV_W] = div_factor_q[1];
					rd_mux[SOURCE_B_LSB +: PRE_W] = div_source_q[1];
				end
				OFF_CHANNEL_STATUS: rd_mux[NCH-1:0] = en_q;
				OFF_IRQ_MASK: rd_mux[NCH-1:0] = imr_q;
				OFF_IRQ_STATUS: rd_mux[NCH-1:0] = isr_q;
				default: begin
				end
			endcase
		end
		pready_d = setup_done;
		prdata_d = prdata_q;
		if (setup_done) begin
			prdata_d = pwrite ? '0 : rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= pready_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign channel_wave_out = wave_q;
	assign irq = irq_q;

	a_flag_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(xfer_rd && paddr == OFF_IRQ_STATUS && ev == '0) |=>
		((isr_q & $past(prdata_q[NCH-1:0])) == '0))
		else $error("status read did not clear reported flags");
	a_event_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(ev != '0) |=> ((isr_q & $past(ev)) == $past(ev)))
		else $error("period end did not set its flag");
	a_irq_from_mask: assert property (@(posedge pclk) disable iff (!presetn)
		irq_q == |(isr_q & imr_q))
		else $error("interrupt line disagrees with flags and mask");
	a_enable_restart: assert property (@(posedge pclk) disable iff (!presetn)
		(xfer_wr && paddr == OFF_CHANNEL_ENABLE && pwdata[0] && !en_q[0]) |=>
		(en_q[0] && st_q[0].count == CNT_RESET && st_q[0].dir == FCPWM_UP))
		else $error("enabled channel did not restart at zero");
	a_level_locked: assert property (@(posedge pclk) disable iff (!presetn)
		(en_q[0] && xfer_wr && in_ch && ch_idx == '0 && ch_sub == SUB_MODE) |=>
		$stable(cfg_q[0].start_level) && $stable(cfg_q[0].center))
		else $error("polarity or alignment changed while enabled");
	a_idle_level: assert property (@(posedge pclk) disable iff (!presetn)
		!en_q[0] |-> wave_q[0] == cfg_q[0].start_level)
		else $error("disabled output not at start level");
	a_fixed_high: assert property (@(posedge pclk) disable iff (!presetn)
		(en_q[0] && cfg_q[0].duty == '0 && !cfg_q[0].start_level) |-> wave_q[0])
		else $error("output not fixed high");
	a_fixed_low: assert property (@(posedge pclk) disable iff (!presetn)
		(en_q[0] && cfg_q[0].duty == cfg_q[0].period && !cfg_q[0].start_level) |-> !wave_q[0])
		else $error("output not fixed low");
	a_divider_off: assert property (@(posedge pclk) disable iff (!presetn)
		(div_factor_q[0] == DIV_RESET) |-> !div_tick[0] && div_cnt_q[0] == DIV_RESET)
		else $error("divider runs with zero factor");
	a_update_waits: assert property (@(posedge pclk) disable iff (!presetn)
		(en_q[0] && !ev[0] && $past(en_q[0])) |=> $stable(cfg_q[0].period))
		else $error("period changed before period end");
	a_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		setup_done |=> pready_q ##1 !pready_q)
		else $error("bus answer not after one wait state");

endmodule

// file: logic/fcpwm_pkg.sv
package fcpwm_pkg;

	localparam int unsigned NUM_CH = 4;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PRESC_W = 10;
	localparam int unsigned PRE_TAPS = 11;
	localparam int unsigned DIV_W = 8;
	localparam int unsigned PRE_W = 4;
	localparam int unsigned SEL_W = 4;
	localparam int unsigned NUM_DIV = 2;

	// Global register offsets.
	localparam logic [ADDR_W-1:0] OFF_CLOCK_GEN_CONFIG = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_CHANNEL_ENABLE = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_CHANNEL_DISABLE = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_CHANNEL_STATUS = 12'h00c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_IRQ_DISABLE = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h018;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h01c;

	// Channel register block: base plus channel times stride plus sub offset.
	localparam logic [ADDR_W-1:0] OFF_CH_BASE = 12'h200;
	localparam logic [ADDR_W-1:0] OFF_CH_END = 12'h280;
	localparam int unsigned CH_IDX_LSB = 5;
	localparam int unsigned CH_IDX_W = 2;
	localparam int unsigned CH_SUB_W = 5;
	localparam logic [CH_SUB_W-1:0] SUB_MODE = 5'h00;
	localparam logic [CH_SUB_W-1:0] SUB_DUTY = 5'h04;
	localparam logic [CH_SUB_W-1:0] SUB_PERIOD = 5'h08;
	localparam logic [CH_SUB_W-1:0] SUB_COUNT = 5'h0c;
	localparam logic [CH_SUB_W-1:0] SUB_UPDATE = 5'h10;

	// Clock generator configuration fields.
	localparam int unsigned FACTOR_A_LSB = 0;
	localparam int unsigned SOURCE_A_LSB = 8;
	localparam int unsigned FACTOR_B_LSB = 16;
	localparam int unsigned SOURCE_B_LSB = 24;

	// Channel mode register fields.
	localparam int unsigned SEL_LSB = 0;
	localparam int unsigned CENTER_BIT = 8;
	localparam int unsigned LEVEL_BIT = 9;
	localparam int unsigned TARGET_BIT = 10;

	// Channel clock selection codes beyond the prescaler taps.
	localparam logic [SEL_W-1:0] SEL_CLOCK_A = 4'hb;
	localparam logic [SEL_W-1:0] SEL_CLOCK_B = 4'hc;

	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;
	localparam logic [PRE_W-1:0] PRE_RESET = 4'h0;

	typedef enum logic [0:0] {
		FCPWM_UP = 1'b0,
		FCPWM_DOWN = 1'b1
	} fcpwm_dir_t;

	typedef struct packed {
		logic [SEL_W-1:0] clk_sel;
		logic center;
		logic start_level;
		logic upd_duty;
		logic [CNT_W-1:0] period;
		logic [CNT_W-1:0] duty;
	} fcpwm_chcfg_t;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		fcpwm_dir_t dir;
		logic upd_pend;
		logic [CNT_W-1:0] upd_val;
	} fcpwm_chst_t;

	localparam fcpwm_chcfg_t CHCFG_RESET = '{
		clk_sel: 4'h0, center: 1'b0, start_level: 1'b0, upd_duty: 1'b0,
		period: 16'h0000, duty: 16'h0000};
	localparam fcpwm_chst_t CHST_RESET = '{
		count: 16'h0000, dir: FCPWM_UP, upd_pend: 1'b0, upd_val: 16'h0000};

endpackage

// file: tb/fcpwm_top_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module fcpwm_top_test;
	import fcpwm_pkg::*;

	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic [DATA_W-1:0] rd;
	logic pready;
	logic irq;
	logic [NUM_CH-1:0] wave;
	int failures;
	int checks;
	int rises[NUM_CH];
	int highs[NUM_CH];
	int sync_diff;
	int exp_hi[NUM_CH] = '{30, 30, 0, 40};
	int exp_ri[NUM_CH] = '{10, 10, 0, 0};

	fcpwm_top #(.NCH(NUM_CH)) DUT (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.channel_wave_out(wave),
		.irq(irq)
	);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// One transfer; the request is held until pready is sampled high.
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
		apb(1'b0, a, '0);
		`CHK(nm, ex, rd)
	endtask

	function automatic logic [ADDR_W-1:0] cha(input int c, input logic [CH_SUB_W-1:0] s);
		return OFF_CH_BASE + (ADDR_W'(c) << CH_IDX_LSB) + ADDR_W'(s);
	endfunction

	function automatic logic [DATA_W-1:0] md(input logic [SEL_W-1:0] sel, input logic ctr,
			input logic lvl, input logic tgt);
		return (DATA_W'(sel) << SEL_LSB) | (DATA_W'(ctr) << CENTER_BIT) |
			(DATA_W'(lvl) << LEVEL_BIT) | (DATA_W'(tgt) << TARGET_BIT);
	endfunction

	task automatic cfg(input int c, input logic [SEL_W-1:0] sel, input logic ctr, input logic lvl,
			input logic [CNT_W-1:0] per, input logic [CNT_W-1:0] dty);
		wr(cha(c, SUB_MODE), md(sel, ctr, lvl, 1'b0));
		wr(cha(c, SUB_PERIOD), DATA_W'(per));
		wr(cha(c, SUB_DUTY), DATA_W'(dty));
	endtask

	// Windows are whole multiples of each period, so counts do not depend on phase.
	task automatic measure(input int n);
		logic [NUM_CH-1:0] prev;
		@(posedge pclk);
		#1;
		prev = wave;
		sync_diff = 0;
		for (int c = 0; c < NUM_CH; c++) begin
			rises[c] = 0;
			highs[c] = 0;
		end
		repeat (n) begin
			@(posedge pclk);
			#1;
			for (int c = 0; c < NUM_CH; c++) begin
				if (wave[c] === 1'b1) highs[c]++;
				if (wave[c] === 1'b1 && prev[c] === 1'b0) rises[c]++;
			end
			if (wave[0] !== wave[1]) sync_diff++;
			prev = wave;
		end
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		$display("unexpected watchdog expected done seen timeout");
		test_done();
	end

	initial begin
		failures = 0;
		checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		`CHK("wave", 4'h0, wave)
		`CHK("irq", 1'b0, irq)
		rdc("clock_gen_config", OFF_CLOCK_GEN_CONFIG, 32'h0000_0000);
		rdc("channel_status", OFF_CHANNEL_STATUS, 32'h0000_0000);
		rdc("irq_mask", OFF_IRQ_MASK, 32'h0000_0000);
		rdc("irq_status", OFF_IRQ_STATUS, 32'h0000_0000);
		for (int c = 0; c < NUM_CH; c++) begin
			rdc("channel_mode", cha(c, SUB_MODE), 32'h0000_0000);
		end
		rdc("unmapped", 12'h100, 32'h0000_0000);
		rdc("count", cha(0, SUB_COUNT), 32'h0000_0000);
		$display("test reset_values done");

		wr(OFF_CLOCK_GEN_CONFIG, 32'h0a05_0203);
		rdc("clock_gen_config", OFF_CLOCK_GEN_CONFIG, 32'h0a05_0203);
		wr(OFF_IRQ_ENABLE, 32'h0000_0005);
		rdc("irq_mask", OFF_IRQ_MASK, 32'h0000_0005);
		wr(OFF_IRQ_DISABLE, 32'h0000_0004);
		rdc("irq_mask", OFF_IRQ_MASK, 32'h0000_0001);
		cfg(2, 4'h0, 1'b0, 1'b1, 16'h0004, 16'h0004);
		repeat (2) @(posedge pclk);
		#1;
		`CHK("wave2", 1'b1, wave[2])
		$display("test config_and_mask done");

		cfg(0, 4'h0, 1'b0, 1'b0, 16'h0004, 16'h0001);
		cfg(1, 4'h0, 1'b0, 1'b0, 16'h0004, 16'h0001);
		cfg(2, 4'h0, 1'b0, 1'b0, 16'h0004, 16'h0004);
		cfg(3, 4'h0, 1'b0, 1'b0, 16'h0004, 16'h0000);
		wr(OFF_CHANNEL_ENABLE, 32'h0000_000f);
		rdc("channel_status", OFF_CHANNEL_STATUS, 32'h0000_000f);
		repeat (8) @(posedge pclk);
		measure(40);
		for (int c = 0; c < NUM_CH; c++) begin
			`CHK("highs", exp_hi[c], highs[c])
			`CHK("rises", exp_ri[c], rises[c])
		end
		`CHK("sync_diff", 0, sync_diff)
		`CHK("irq", 1'b1, irq)
		apb(1'b0, OFF_IRQ_STATUS, '0);
		`CHK("irq_status", 4'hf, rd[3:0])
		wr(cha(0, SUB_MODE), md(4'h0, 1'b1, 1'b1, 1'b0));
		rdc("channel_mode", cha(0, SUB_MODE), 32'h0000_0000);
		$display("test left_aligned done");

		wr(cha(0, SUB_UPDATE), 32'h0000_0008);
		repeat (12) @(posedge pclk);
		rdc("period", cha(0, SUB_PERIOD), 32'h0000_0008);
		measure(48);
		`CHK("rises0", 6, rises[0])
		`CHK("highs0", 42, highs[0])
		`CHK("rises1", 12, rises[1])
		wr(cha(0, SUB_MODE), md(4'h0, 1'b0, 1'b0, 1'b1));
		wr(cha(0, SUB_UPDATE), 32'h0000_0000);
		repeat (20) @(posedge pclk);
		measure(16);
		`CHK("highs0", 16, highs[0])
		wr(cha(0, SUB_UPDATE), 32'h0000_0008);
		repeat (20) @(posedge pclk);
		measure(16);
		`CHK("highs0", 0, highs[0])
		wr(OFF_IRQ_DISABLE, 32'h0000_0001);
		apb(1'b0, OFF_IRQ_STATUS, '0);
		repeat (2) @(posedge pclk);
		#1;
		`CHK("irq", 1'b0, irq)
		wr(OFF_CHANNEL_DISABLE, 32'h0000_000f);
		rdc("channel_status", OFF_CHANNEL_STATUS, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		#1;
		`CHK("wave", 4'h0, wave)
		$display("test update done");

		cfg(0, SEL_CLOCK_B, 1'b0, 1'b0, 16'h0008, 16'h0004);
		cfg(1, 4'h0, 1'b1, 1'b0, 16'h0004, 16'h0001);
		cfg(2, 4'h1, 1'b0, 1'b0, 16'h0004, 16'h0001);
		cfg(3, SEL_CLOCK_A, 1'b0, 1'b0, 16'h0002, 16'h0001);
		wr(OFF_CLOCK_GEN_CONFIG, 32'h0005_0003);
		wr(OFF_CHANNEL_ENABLE, 32'h0000_000f);
		repeat (20) @(posedge pclk);
		measure(120);
		`CHK("rises0", 3, rises[0])
		`CHK("rises1", 15, rises[1])
		`CHK("rises2", 15, rises[2])
		`CHK("rises3", 20, rises[3])
		$display("test clocks_and_center done");
		test_done();
	end

endmodule
